// *** hdl/sttu_pkg.sv ***
package sttu_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS     = 10;
	localparam int US_NS      = 1000;
	localparam int CYC_PER_US = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRESC_W    = $clog2(CYC_PER_US);
	localparam logic [PRESC_W-1:0] PRESC_MAX = PRESC_W'(CYC_PER_US - 1);
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int TB_W      = 64;
	localparam int SEQ_W     = 32;
	localparam int PIX_W     = 8;
	localparam int DISP_W    = 12;
	localparam int Q_N       = 16;
	localparam int CTRL_W    = 5;
	localparam logic [DISP_W-1:0] DISP_INVALID = 12'hFFF;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_PERIOD  = 8'h04;
	localparam logic [7:0] A_WIDTH   = 8'h08;
	localparam logic [7:0] A_TIME_LO = 8'h0C;
	localparam logic [7:0] A_TIME_HI = 8'h10;
	localparam logic [7:0] A_SEQ     = 8'h14;
	localparam logic [7:0] A_DROP    = 8'h18;
	localparam logic [1:0] Q_PAGE    = 2'h1;
	localparam int C_TRIG0 = 0;
	localparam int C_TRIG1 = 1;
	localparam int C_SYNC  = 2;
	localparam int C_TSRC  = 3;
	localparam int C_NET   = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h03;
	localparam logic [31:0]       PERIOD_RST = 32'h0000_8235;
	localparam logic [31:0]       WIDTH_RST  = 32'h0000_0064;
	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic              valid;
		logic              sof;
		logic              rej;
		logic [PIX_W-1:0]  pix;
		logic [DISP_W-1:0] disp;
	} sttu_pix_s;
	typedef struct packed {
		logic [TB_W-1:0]  ts;
		logic [SEQ_W-1:0] seq;
	} sttu_tag_s;
	typedef struct packed {
		logic                   valid;
		logic                   sof;
		logic [PIX_W-1:0]       pix;
		logic [DISP_W-1:0]      disp;
		logic signed [TB_W-1:0] ts;
		logic [SEQ_W-1:0]       seq;
	} sttu_out_s;
endpackage

// *** hdl/sttu_sync.sv ***
`timescale 1ns/1ns
module sttu_sync
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic din,
	output logic      rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} sttu_sync_s;
	sttu_sync_s st;
	sttu_sync_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// Edge taken after the second stage only
		next_st.rise = st.s2 & ~st.s3;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign rise = st.rise;

	property p_sync_edge;
		@(posedge clk_sys) disable iff (rst)
		rise |-> $past(din, 3) && !$past(din, 4);
	endproperty
	a_sync_edge: assert property (p_sync_edge)
		else $error("sync edge without rising input");
endmodule

// *** hdl/sttu_trig.sv ***
`timescale 1ns/1ns
module sttu_trig
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        en,
	input  wire logic        tick,
	input  wire logic [31:0] period,
	input  wire logic [31:0] width,
	output logic             pulse,
	output logic             fire
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        pulse;
		logic        fire;
	} sttu_trig_s;
	sttu_trig_s  st;
	sttu_trig_s  next_st;
	logic [31:0] cnt_inc;

	always_comb
	begin
		next_st = st;
		next_st.fire = 1'b0;
		cnt_inc = st.cnt + 32'h0000_0001;
		if (!en)
		begin
			next_st.cnt = '0;
			next_st.pulse = 1'b0;
		end
		else if (tick)
		begin
			if (st.cnt == '0)
			begin
				next_st.pulse = (width != '0);
				next_st.fire = 1'b1;
			end
			// Count of ticks since fire reaches width: one tick per unit
			else if (st.cnt == width)
				next_st.pulse = 1'b0;
			next_st.cnt = (cnt_inc >= period) ? '0 : cnt_inc;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign pulse = st.pulse;
	assign fire  = st.fire;

	property p_trig_idle;
		@(posedge clk_sys) disable iff (rst)
		!en |=> !pulse;
	endproperty
	a_trig_idle: assert property (p_trig_idle)
		else $error("trigger high while disabled");

	property p_trig_fire;
		@(posedge clk_sys) disable iff (rst)
		fire && width != '0 |-> pulse;
	endproperty
	a_trig_fire: assert property (p_trig_fire)
		else $error("fire without pulse start");
endmodule

// *** hdl/sttu_top.sv ***
// How it works
// - Two trigger outputs start both cameras at the same instant.
// - Trigger outputs idle low and go high for the pulse.
// - Pulse width and repetition period are software settings.
// - Sync mode turns trigger line 0 into an input, output off.
// - In sync mode every rising sync edge clears the time base.
// - Without sync the time base starts at zero and runs free.
// - Software may load epoch microseconds from a time server.
// - Every output pair carries timestamp and sequence number.
// - Timestamps are microsecond counts from the time base.
// - Timestamp source is trigger moment or capture moment.
// - Network frames pass their own timestamp and sequence.
// - Sync between capture and tagging gives a negative stamp.
// - Negative stamp is the pair stamp (trigger or capture time) minus sync time.
// - Disparity is 12 bits, low 4 bits are fraction.
// - Rejected disparities are sent as all ones.
// - Disparity is per left pixel, horizontal offset only.
// - Left rectified pixel goes out with each disparity.
// - Projection matrix goes out with every disparity map.
// - Only left/right frames with matching stamps are paired.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module sttu_top
#(
	parameter int MATCH_US = 1000
)
(
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [31:0]                  reg_rdata,
	input  wire logic                    trig0_in,
	output logic                         trig0_out,
	output logic                         trig0_oe_n,
	output logic                         trig1_out,
	input  wire logic                    cam_l_cap,
	input  wire logic                    cam_r_cap,
	input  wire sttu_pkg::sttu_pix_s     in_pix,
	input  wire sttu_pkg::sttu_tag_s     net_tag,
	output sttu_pkg::sttu_out_s          out,
	output logic [sttu_pkg::Q_N*32-1:0]  q_out
);
	import sttu_pkg::*;

	typedef struct packed {
		logic [CTRL_W-1:0]    ctrl;
		logic [31:0]          period;
		logic [31:0]          width;
		logic [Q_N-1:0][31:0] q;
		logic [Q_N-1:0][31:0] q_out;
		logic [PRESC_W-1:0]   presc;
		logic [TB_W-1:0]      tb;
		logic [TB_W-1:0]      sync_at;
		logic [TB_W-1:0]      trig_ts;
		logic [TB_W-1:0]      l_ts;
		logic [TB_W-1:0]      r_ts;
		logic [TB_W-1:0]      pair_ts;
		logic [SEQ_W-1:0]     seq;
		logic                 l_ok;
		logic                 r_ok;
		logic                 pair_ok;
		logic                 trig_pend;
		logic                 sync_since;
		logic                 in_frame;
		logic                 trig0;
		logic                 trig1;
		logic                 oe_n;
		logic [15:0]          drop;
		logic [31:0]          rdata;
		sttu_out_s            out;
	} sttu_top_s;

	sttu_top_s       st;
	sttu_top_s       next_st;
	logic            tick;
	logic            sync_rise;
	logic            sync_hit;
	logic            en0;
	logic            t0_pulse;
	logic            t0_fire;
	logic            t1_pulse;
	logic            t1_fire;
	logic            acc;
	logic [TB_W-1:0] gap;

	// ------------------------------------------------------------
	// Trigger generators and sync input
	// ------------------------------------------------------------
	// line 0 output off in sync mode
	assign en0 = st.ctrl[C_TRIG0] & ~st.ctrl[C_SYNC];

	sttu_trig u_trig0
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.en      (en0),
		.tick    (tick),
		.period  (st.period),
		.width   (st.width),
		.pulse   (t0_pulse),
		.fire    (t0_fire)
	);

	sttu_trig u_trig1
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.en      (st.ctrl[C_TRIG1]),
		.tick    (tick),
		.period  (st.period),
		.width   (st.width),
		.pulse   (t1_pulse),
		.fire    (t1_fire)
	);

	sttu_sync u_sync
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (trig0_in),
		.rise    (sync_rise)
	);

	assign tick = (st.presc == PRESC_MAX);
	// edge counts only in sync mode
	assign sync_hit = sync_rise & st.ctrl[C_SYNC];
	assign acc = in_pix.sof ? (st.ctrl[C_NET] | st.pair_ok) : st.in_frame;
	assign gap = (st.l_ts > st.r_ts) ? st.l_ts - st.r_ts
		: st.r_ts - st.l_ts;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.out.valid = 1'b0;
		next_st.out.sof = 1'b0;
		next_st.rdata = '0;

		next_st.presc = tick ? '0 : st.presc + 1'b1;
		if (tick)
			next_st.tb = st.tb + 64'h1;

		if (reg_wr)
		begin
			case (reg_addr)
				A_CTRL:
					next_st.ctrl = reg_wdata[CTRL_W-1:0];
				A_PERIOD:
					next_st.period = reg_wdata;
				A_WIDTH:
					next_st.width = reg_wdata;
				A_TIME_LO:
				begin
					next_st.tb[31:0] = reg_wdata;
					next_st.presc = '0;
				end
				A_TIME_HI:
					next_st.tb[63:32] = reg_wdata;
				default:
					if (reg_addr[7:6] == Q_PAGE)
						next_st.q[reg_addr[5:2]] = reg_wdata;
			endcase
		end

		if (reg_rd)
		begin
			case (reg_addr)
				A_CTRL:
					next_st.rdata = 32'(st.ctrl);
				A_PERIOD:
					next_st.rdata = st.period;
				A_WIDTH:
					next_st.rdata = st.width;
				A_TIME_LO:
					next_st.rdata = st.tb[31:0];
				A_TIME_HI:
					next_st.rdata = st.tb[63:32];
				A_SEQ:
					next_st.rdata = st.seq;
				A_DROP:
					next_st.rdata = 32'(st.drop);
				default:
					if (reg_addr[7:6] == Q_PAGE)
						next_st.rdata = st.q[reg_addr[5:2]];
			endcase
		end

		if (t0_fire | t1_fire)
		begin
			next_st.trig_ts = st.tb;
			next_st.trig_pend = 1'b1;
			if (!st.pair_ok)
				next_st.sync_since = 1'b0;
		end

		if (sync_hit)
		begin
			next_st.sync_at = st.tb;
			next_st.tb = '0;
			next_st.presc = '0;
			if (st.pair_ok | (st.trig_pend & ~st.ctrl[C_TSRC]))
				next_st.sync_since = 1'b1;
		end

		// Tagging runs before pairing so a fresh pair is not lost
		if (in_pix.valid)
		begin
			next_st.in_frame = acc;
			if (in_pix.sof && acc)
			begin
				next_st.out.sof = 1'b1;
				next_st.q_out = st.q;
				if (st.ctrl[C_NET])
				begin
					next_st.out.ts = $signed(net_tag.ts);
					next_st.out.seq = net_tag.seq;
				end
				else
				begin
					if (st.sync_since)
						next_st.out.ts = $signed(st.pair_ts - st.sync_at);
					else
						next_st.out.ts = $signed(st.pair_ts);
					next_st.out.seq = st.seq;
					next_st.seq = st.seq + 32'h1;
					next_st.pair_ok = 1'b0;
					next_st.sync_since = 1'b0;
				end
			end
			else if (in_pix.sof)
				next_st.drop = st.drop + 16'h1;
			if (acc)
			begin
				next_st.out.valid = 1'b1;
				next_st.out.pix = in_pix.pix;
				next_st.out.disp = in_pix.disp;
				if (in_pix.rej)
					next_st.out.disp = DISP_INVALID;
			end
		end

		if (cam_l_cap)
		begin
			next_st.l_ok = 1'b1;
			next_st.l_ts = st.tb;
		end
		if (cam_r_cap)
		begin
			next_st.r_ok = 1'b1;
			next_st.r_ts = st.tb;
		end

		if (st.l_ok && st.r_ok)
		begin
			if (gap <= 64'(MATCH_US))
			begin
				if (next_st.pair_ok)
					next_st.drop = next_st.drop + 16'h1;
				next_st.pair_ok = 1'b1;
				next_st.pair_ts = st.ctrl[C_TSRC] ? st.tb : st.trig_ts;
				next_st.trig_pend = 1'b0;
				next_st.l_ok = cam_l_cap;
				next_st.r_ok = cam_r_cap;
			end
			else
			begin
				next_st.drop = next_st.drop + 16'h1;
				if (st.l_ts < st.r_ts)
					next_st.l_ok = cam_l_cap;
				else
					next_st.r_ok = cam_r_cap;
			end
		end

		next_st.trig0 = t0_pulse & en0;
		next_st.trig1 = t1_pulse & st.ctrl[C_TRIG1];
		// release the pin in sync mode
		next_st.oe_n = st.ctrl[C_SYNC];
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st <= '0;
			st.ctrl <= CTRL_RST;
			st.period <= PERIOD_RST;
			st.width <= WIDTH_RST;
		end
		else
			st <= next_st;
	end

	assign reg_rdata  = st.rdata;
	assign trig0_out  = st.trig0;
	assign trig0_oe_n = st.oe_n;
	assign trig1_out  = st.trig1;
	assign out        = st.out;
	assign q_out      = st.q_out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_local_tag;
		in_pix.valid && in_pix.sof && !st.ctrl[C_NET] && st.pair_ok;
	endsequence

	property p_seq_step;
		s_local_tag |=> out.sof && out.seq == $past(st.seq)
			&& st.seq == $past(st.seq) + 32'h1;
	endproperty
	a_seq_step: assert property (p_seq_step)
		else $error("sequence did not step on tagged pair");

	property p_neg_stamp;
		s_local_tag ##0 st.sync_since |=> out.ts < 0;
	endproperty
	a_neg_stamp: assert property (p_neg_stamp)
		else $error("stamp not negative after sync");

	property p_trig0_off;
		st.ctrl[C_SYNC] |=> !trig0_out && trig0_oe_n;
	endproperty
	a_trig0_off: assert property (p_trig0_off)
		else $error("trigger 0 driven in sync mode");

	property p_tb_clear;
		sync_hit |=> st.tb == '0;
	endproperty
	a_tb_clear: assert property (p_tb_clear)
		else $error("time base not cleared by sync edge");

	property p_tb_count;
		tick && !reg_wr && !sync_hit |=> st.tb == $past(st.tb) + 64'h1;
	endproperty
	a_tb_count: assert property (p_tb_count)
		else $error("time base did not advance on tick");

	property p_invalid;
		in_pix.valid && in_pix.rej && acc |=> out.disp == DISP_INVALID;
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("rejected disparity not marked invalid");

	property p_unpaired;
		in_pix.valid && in_pix.sof && !st.ctrl[C_NET] && !st.pair_ok
			|=> !out.valid;
	endproperty
	a_unpaired: assert property (p_unpaired)
		else $error("unpaired frame passed");

	property p_net_copy;
		in_pix.valid && in_pix.sof && st.ctrl[C_NET]
			|=> out.seq == $past(net_tag.seq)
			&& out.ts == $signed($past(net_tag.ts));
	endproperty
	a_net_copy: assert property (p_net_copy)
		else $error("network stamp not copied");
endmodule

// *** bench/sttu_cam_model.sv ***
`timescale 1ns/1ns
module sttu_cam_model
(
	input  wire logic       clk_sys,
	input  wire logic       trig,
	input  wire logic [7:0] lag,
	output logic            cam_l_cap,
	output logic            cam_r_cap
);
	// ------------------------------------------------------------
	// Camera pair, left capture lag+2 and right capture lag+3 cycles after trigger rise
	// ------------------------------------------------------------
	logic prev = 1'b0;
	int   cnt  = -1;
	initial
	begin
		cam_l_cap = 1'b0;
		cam_r_cap = 1'b0;
	end
	always @(posedge clk_sys)
	begin
		prev      <= trig;
		cam_l_cap <= (cnt == 1);
		cam_r_cap <= (cnt == 0);
		if (trig && !prev)
			cnt <= int'(lag) + 1;
		else if (cnt >= 0)
			cnt <= cnt - 1;
	end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
	import sttu_pkg::*;
	logic              clk_sys   = 1'b0;
	logic              rst       = 1'b1;
	logic [7:0]        reg_addr  = '0;
	logic [31:0]       reg_wdata = '0;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic              trig0_in  = 1'b0;
	logic [7:0]        lag       = 8'h03;
	sttu_pix_s         in_pix    = '0;
	sttu_tag_s         net_tag   = '0;
	logic [31:0]       r         = 32'hF94380DD;
	logic [31:0]       reg_rdata;
	logic              trig0_out;
	logic              trig0_oe_n;
	logic              trig1_out;
	logic              cam_l_cap;
	logic              cam_r_cap;
	sttu_out_s         out;
	logic [Q_N*32-1:0] q_out;
	logic [31:0]       v;
	logic [31:0]       s;
	logic [31:0]       qe [Q_N];
	logic [63:0]       got_ts;
	logic [63:0]       got_seq;
	int                fail_count = 0;
	int                n_tests    = 0;
	int                n;
	int                h;

	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	sttu_top uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .trig0_in(trig0_in), .trig0_out(trig0_out),
		.trig0_oe_n(trig0_oe_n), .trig1_out(trig1_out),
		.cam_l_cap(cam_l_cap), .cam_r_cap(cam_r_cap), .in_pix(in_pix),
		.net_tag(net_tag), .out(out), .q_out(q_out));

	// Line 0 may be the sync input, so cameras follow line 1
	sttu_cam_model cam (.clk_sys(clk_sys), .trig(trig1_out), .lag(lag),
		.cam_l_cap(cam_l_cap), .cam_r_cap(cam_r_cap));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [DISP_W-1:0] exp_disp(input sttu_pix_s b);
		return b.rej ? DISP_INVALID : b.disp;
	endfunction

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Bounded wait on a capture pulse or a trigger level
	task automatic wt(input logic cap, input logic lv, output int c);
		c = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			c++;
		end
		while (((cap ? cam_r_cap : trig1_out) !== lv) && c < 5000);
		if (c >= 5000)
		begin
			fail_count++;
			print_verdict();
		end
	endtask

	// Eight back-to-back beats, each checked one cycle later
	task automatic frame(input logic en);
		sttu_pix_s b;
		sttu_pix_s p;
		int        nv;
		p  = '0;
		nv = 0;
		for (int i = 0; i <= 8; i++)
		begin
			b = '0;
			if (i < 8)
			begin
				r       = lfsr(r);
				b.valid = 1'b1;
				b.sof   = (i == 0);
				b.rej   = r[31] | (i == 3);
				b.pix   = r[7:0];
				b.disp  = (i == 5) ? 12'hFFE : r[19:8];
			end
			@(posedge clk_sys);
			in_pix <= b;
			#1;
			if (out.valid === 1'b1)
			begin
				nv++;
				if (p.sof)
				begin
					got_ts  = out.ts;
					got_seq = out.seq;
				end
				chk("pix", p.pix, out.pix);
				chk("disp", exp_disp(p), out.disp);
				chk("sof", p.sof, out.sof);
			end
			p = b;
		end
		chk("beats", en ? 8 : 0, nv);
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(A_CTRL, v);
		chk("ctrl", CTRL_RST, v);
		wr(A_CTRL, 32'h0);
		wr(A_SEQ, 32'h5A);
		rd(A_PERIOD, v);
		chk("period", PERIOD_RST, v);
		rd(A_WIDTH, v);
		chk("width", WIDTH_RST, v);
		rd(A_TIME_LO, v);
		chk("time0", 0, v);
		rd(A_SEQ, v);
		chk("seq_ro", 0, v);
		rd(8'h3C, v);
		chk("unmapped", 0, v);
		rd(A_DROP, s);
		frame(1'b0);
		rd(A_DROP, v);
		chk("drop", s + 1, v);
		wr(A_TIME_LO, 32'h0);
		wr(A_TIME_HI, 32'h0);
		repeat (1000) @(posedge clk_sys);
		rd(A_TIME_LO, v);
		chk("rate", 10, v);
		for (int i = 0; i < Q_N; i++)
		begin
			r     = lfsr(r);
			qe[i] = r;
			wr({Q_PAGE, 4'(i), 2'b00}, r);
		end
		wr(A_PERIOD, 32'd20);
		wr(A_WIDTH, 32'd5);
		wr(A_CTRL, 32'h03);
		wt(0, 1, n);
		chk("lockstep", trig1_out, trig0_out);
		wt(0, 0, h);
		chk("pulse", 5 * CYC_PER_US, h);
		wt(0, 1, n);
		chk("repeat", 20 * CYC_PER_US, h + n);
		for (int k = 0; k < 2; k++)
		begin
			wr(A_CTRL, k ? 32'h0B : 32'h03);
			rd(A_SEQ, s);
			wt(1, 1, n);
			repeat (3) @(posedge clk_sys);
			frame(1'b1);
			chk("seq", s, got_seq);
			chk("ts_sign", 0, got_ts[63]);
			rd(A_SEQ, v);
			chk("seq_step", s + 1, v);
		end
		for (int i = 0; i < Q_N; i++)
			chk("q", qe[i], q_out[32*i +: 32]);
		rd(A_SEQ, s);
		wr(A_CTRL, 32'h10);
		r = lfsr(r);
		net_tag <= {r, ~r, lfsr(r)};
		frame(1'b1);
		chk("net_ts", net_tag.ts, got_ts);
		chk("net_seq", net_tag.seq, got_seq);
		rd(A_SEQ, v);
		chk("net_keep", s, v);
		wr(A_CTRL, 32'h06);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("oe_off", 1, trig0_oe_n);
		chk("t0_off", 0, trig0_out);
		@(posedge clk_sys);
		trig0_in <= 1'b1;
		repeat (10) @(posedge clk_sys);
		trig0_in <= 1'b0;
		rd(A_TIME_LO, v);
		chk("sync_clr", 1, v <= 1);
		lag = 8'd250;
		wt(1, 1, n);
		@(posedge clk_sys);
		trig0_in <= 1'b1;
		repeat (5) @(posedge clk_sys);
		trig0_in <= 1'b0;
		frame(1'b1);
		chk("neg", 1, $signed(got_ts) < 0);
		chk("neg_mag", 1, $signed(got_ts) > -64'sd20);
		print_verdict();
	end
endmodule
